//--- src/cpu_regs_pkg.sv
// Purpose: Shared constants and types for the register file and flag unit
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Command word fields and event codes are used by software and bench
package cpu_regs_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int         ADDR_BITS     = 8;
  localparam logic [7:0] OFS_ACC_HIGH  = 8'h00;
  localparam logic [7:0] OFS_ACC_LOW   = 8'h04;
  localparam logic [7:0] OFS_PAIRED    = 8'h08;
  localparam logic [7:0] OFS_PAGE      = 8'h0C;
  localparam logic [7:0] OFS_INDEX1    = 8'h10;
  localparam logic [7:0] OFS_INDEX2    = 8'h14;
  localparam logic [7:0] OFS_PROG_SP   = 8'h18;
  localparam logic [7:0] OFS_HW_SP     = 8'h1C;
  localparam logic [7:0] OFS_PC        = 8'h20;
  localparam logic [7:0] OFS_FLAGS     = 8'h24;
  localparam logic [7:0] OFS_OPERAND   = 8'h28;
  localparam logic [7:0] OFS_COMMAND   = 8'h2C;
  localparam logic [7:0] OFS_EFF_ADDR  = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h34;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_DECERR   = 2'h3;
  // ----------------------------------------
  // Flag bits and reset values
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_F = 6;
  localparam int FLAG_E = 7;
  localparam logic [7:0] FLAGS_RESET   = 8'h50;
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_QUICK    = 8'h81;
  localparam int         WIDE_FIRST    = 4;
  // ----------------------------------------
  // Command word
  // ----------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_SEL_LSB  = 4;
  localparam int CMD_STK_BIT  = 6;
  localparam int CMD_OFS_LSB  = 8;
  localparam int CMD_AUTO_LSB = 10;
  localparam logic [3:0] OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3;
  localparam logic [3:0] OP_CMP = 4'h4, OP_NEG = 4'h5, OP_ADD16 = 4'h6, OP_SUB16 = 4'h7;
  localparam logic [3:0] OP_MUL = 4'h8, OP_DIRECT = 4'h9, OP_INDEX = 4'hA, OP_PUSH = 4'hB;
  localparam logic [3:0] OP_PULL = 4'hC, OP_TRAP = 4'hD, OP_RETURN = 4'hE, OP_PCREL = 4'hF;
  localparam logic [1:0] OFS_NONE = 2'h0, OFS_CONST = 2'h1, OFS_ACC = 2'h2, OFS_PAIR = 2'h3;
  localparam logic [1:0] AUTO_NONE = 2'h0, AUTO_INC1 = 2'h1, AUTO_INC2 = 2'h2, AUTO_DEC1 = 2'h3;
  localparam logic [2:0] EV_NONE = 3'h0, EV_NMI = 3'h1, EV_QUICK = 3'h2, EV_STD = 3'h3;
  localparam logic [2:0] EV_SOFT1 = 3'h4, EV_SOFT2 = 3'h5, EV_SOFT3 = 3'h6;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'h0,
    BUS_WRITE = 2'h1,
    BUS_READ  = 2'h2
  } bus_state_t;

  typedef struct packed {
    logic [7:0]           acc_high;
    logic [7:0]           acc_low;
    logic [7:0]           page_base;
    logic [7:0]           flags_register;
    logic [15:0]          index_first;
    logic [15:0]          index_second;
    logic [15:0]          program_stack_ptr;
    logic [15:0]          hardware_stack_ptr;
    logic [15:0]          program_counter;
    logic [15:0]          operand;
    logic [15:0]          command;
    logic [15:0]          eff_addr;
    logic                 cmd_pending;
    logic                 nmi_armed;
    logic                 nmi_pend;
    logic [2:0]           sync_nmi;
    logic [1:0]           sync_quick;
    logic [1:0]           sync_std;
    logic [7:0]           stacked_mask;
    logic [2:0]           event_code;
    logic                 event_strobe;
    bus_state_t           state;
    logic                 aw_held;
    logic                 w_held;
    logic [ADDR_BITS-1:0] aw_addr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic                 bvalid;
    logic                 rvalid;
    logic [1:0]           bresp;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
  } core_state_t;
endpackage

//--- src/cpu_register_file_and_flags.sv
// Purpose: Programmer-visible registers, flag logic and interrupt entry
// Assumes: Software drives operations through the command register
// Notes:   A command runs in the cycle after its write is taken
// Function
// [RL1] Paired accumulator is high byte first, low byte second, as one 16-bit word.
// [RL2] Direct addressing puts the page base on address bits 15 to 8.
// [RL3] Reset clears the page base to zero.
// [RL4] Indexed address is pointer plus optional constant or accumulator offset.
// [RL5] Auto-increment and auto-decrement modes step the chosen pointer.
// [RL6] Either index register or either stack pointer can be the indexed base.
// [RL7] Stack pointers point at the last pushed item.
// [RL8] Traps and interrupts use the hardware stack; program stack moves only by command.
// [RL9] Push and pull take any register subset on either stack.
// [RL10] Program counter is readable and serves as base for relative addressing.
// [RL11] Carry flag takes the adder carry out on additions.
// [RL12] Subtract, compare, negate and borrow-subtract store the inverted carry.
// [RL13] Overflow flag is carry out of top bit xor carry into it.
// [RL14] Zero flag is set exactly when the result is all zero.
// [RL15] Negative flag copies the result's top bit.
// [RL16] Standard request is ignored while its mask bit is one.
// [RL17] Nonmaskable, quick, standard, reset and first trap set the standard mask.
// [RL18] Nonmaskable requests wait until the hardware stack pointer is first written; the code drops edges that come before that write.
// [RL19] Quick request stacks only flags and program counter.
// [RL20] Unsigned 8 by 8 multiply gives a 16-bit paired result.
// [RL21] Half carry records bit 3 carry on 8-bit add and add-with-carry only.
// [RL22] Quick mask blocks quick requests; set by nonmaskable, quick, first trap, reset.
// [RL23] Entire bit marks full stacking; return uses stacked copy to size unstacking.
// [RL24] Paired write updates both accumulators in the same cycle.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags
  import cpu_regs_pkg::*;
(
  input  wire logic                 aclk,            // Bus clock, 10 MHz
  input  wire logic                 aresetn,         // Synchronous reset, active low
  input  wire logic [ADDR_BITS-1:0] awaddr,          // Write address
  input  wire logic                 awvalid,         // Write address valid
  output logic                      awready,         // Write address ready
  input  wire logic [31:0]          wdata,           // Write data
  input  wire logic [3:0]           wstrb,           // Write byte strobes
  input  wire logic                 wvalid,          // Write data valid
  output logic                      wready,          // Write data ready
  output logic [1:0]                bresp,           // Write response
  output logic                      bvalid,          // Write response valid
  input  wire logic                 bready,          // Write response ready
  input  wire logic [ADDR_BITS-1:0] araddr,          // Read address
  input  wire logic                 arvalid,         // Read address valid
  output logic                      arready,         // Read address ready
  output logic [31:0]               rdata,           // Read data
  output logic [1:0]                rresp,           // Read response
  output logic                      rvalid,          // Read data valid
  input  wire logic                 rready,          // Read data ready
  input  wire logic                 nmi_n,           // Nonmaskable request pin, active low
  input  wire logic                 quick_request_n, // Quick request pin, active low
  input  wire logic                 std_request_n,   // Standard request pin, active low
  output logic [15:0]               addr_out,        // Last effective address
  output logic [2:0]                event_code,      // Last trap or interrupt taken
  output logic                      event_strobe     // One cycle per trap or interrupt
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // {half, overflow, carry, result}
  function automatic logic [10:0] alu8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] sum;
    logic [4:0] lo;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {lo[4], sum[8] ^ a[7] ^ b[7] ^ sum[7], sum[8], sum[7:0]}; // [RL13] [RL21]
  endfunction
  // {overflow, carry, result}
  function automatic logic [17:0] alu16(input logic [15:0] a, input logic [15:0] b, input logic cin);
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
    return {sum[16] ^ a[15] ^ b[15] ^ sum[15], sum[16], sum[15:0]}; // [RL13]
  endfunction
  function automatic logic [3:0] stack_bytes(input logic [7:0] mask);
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      cnt = cnt + (mask[i] ? ((i >= WIDE_FIRST) ? 4'h2 : 4'h1) : 4'h0);
    end
    return cnt;
  endfunction
  function automatic logic [15:0] ptr_get(input core_state_t st, input logic [1:0] sel);
    case (sel)
      2'h0:    return st.index_first;
      2'h1:    return st.index_second;
      2'h2:    return st.program_stack_ptr;
      default: return st.hardware_stack_ptr;
    endcase
  endfunction
  // Entry saves the entire bit first so the stacked copy carries it
  function automatic core_state_t enter(input core_state_t st, input logic [2:0] kind);
    core_state_t r;
    logic        full;
    r    = st;
    full = (kind != EV_QUICK);
    r.flags_register[FLAG_E] = full; // [RL23]
    if (kind != EV_SOFT2 && kind != EV_SOFT3) begin
      r.flags_register[FLAG_I] = 1'b1; // [RL17]
    end
    if (kind == EV_NMI || kind == EV_QUICK || kind == EV_SOFT1) begin
      r.flags_register[FLAG_F] = 1'b1; // [RL22]
    end
    r.stacked_mask       = full ? MASK_FULL : MASK_QUICK; // [RL19]
    r.hardware_stack_ptr = st.hardware_stack_ptr - {12'h000, stack_bytes(r.stacked_mask)}; // [RL7] [RL8]
    r.event_code         = kind;
    r.event_strobe       = 1'b1;
    return r;
  endfunction
  // {hit, data}
  function automatic logic [32:0] reg_read(input core_state_t st, input logic [ADDR_BITS-1:0] a);
    case (a)
      OFS_ACC_HIGH: return {1'b1, 24'h00_0000, st.acc_high};
      OFS_ACC_LOW:  return {1'b1, 24'h00_0000, st.acc_low};
      OFS_PAIRED:   return {1'b1, 16'h0000, st.acc_high, st.acc_low}; // [RL1]
      OFS_PAGE:     return {1'b1, 24'h00_0000, st.page_base};
      OFS_INDEX1:   return {1'b1, 16'h0000, st.index_first};
      OFS_INDEX2:   return {1'b1, 16'h0000, st.index_second};
      OFS_PROG_SP:  return {1'b1, 16'h0000, st.program_stack_ptr};
      OFS_HW_SP:    return {1'b1, 16'h0000, st.hardware_stack_ptr};
      OFS_PC:       return {1'b1, 16'h0000, st.program_counter}; // [RL10]
      OFS_FLAGS:    return {1'b1, 24'h00_0000, st.flags_register};
      OFS_OPERAND:  return {1'b1, 16'h0000, st.operand};
      OFS_COMMAND:  return {1'b1, 16'h0000, st.command};
      OFS_EFF_ADDR: return {1'b1, 16'h0000, st.eff_addr};
      OFS_STATUS:   return {1'b1, 16'h0000, st.stacked_mask, 1'b0, st.event_code, 2'h0, st.nmi_pend, st.nmi_armed};
      default:      return {1'b0, 32'h0000_0000};
    endcase
  endfunction
  // ----------------------------------------
  // State
  // ----------------------------------------
  core_state_t s;
  core_state_t n;

  always_comb begin
    logic [32:0] rd;
    logic [31:0] mv;
    logic [10:0] a8;
    logic [17:0] a16;
    logic [15:0] base;
    logic [15:0] ofs;
    logic [15:0] prod;
    logic [3:0]  op;
    logic [3:0]  cnt;
    logic        flag8;
    logic        is_sub;
    logic        store;
    logic        wrote;
    rd     = 33'h0_0000_0000;
    mv     = 32'h0000_0000;
    a8     = 11'h000;
    a16    = 18'h0_0000;
    base   = 16'h0000;
    ofs    = 16'h0000;
    prod   = 16'h0000;
    op     = s.command[CMD_OP_LSB +: 4];
    cnt    = 4'h0;
    flag8  = 1'b0;
    is_sub = 1'b0;
    store  = 1'b0;
    wrote  = 1'b0;
    n      = s;
    n.event_strobe = 1'b0;
    n.sync_nmi   = {s.sync_nmi[1], s.sync_nmi[0], ~nmi_n};
    n.sync_quick = {s.sync_quick[0], ~quick_request_n};
    n.sync_std   = {s.sync_std[0], ~std_request_n};
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    if (awvalid && s.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_held = 1'b1;
      n.wdata  = wdata;
      n.wstrb  = wstrb;
    end
    case (s.state)
      BUS_IDLE: begin
        if (arvalid && s.arready) begin
          rd      = reg_read(s, araddr);
          n.rdata = rd[31:0];
          n.rresp = rd[32] ? RESP_OKAY : RESP_DECERR;
          n.rvalid = 1'b1;
          n.state  = BUS_READ;
        end else if (s.aw_held && s.w_held) begin
          rd = reg_read(s, s.aw_addr);
          for (int i = 0; i < 4; i++) begin
            mv[i*8 +: 8] = s.wstrb[i] ? s.wdata[i*8 +: 8] : rd[i*8 +: 8];
          end
          wrote = 1'b1;
          case (s.aw_addr)
            OFS_ACC_HIGH: n.acc_high = mv[7:0];
            OFS_ACC_LOW:  n.acc_low  = mv[7:0];
            OFS_PAIRED: begin
              n.acc_high = mv[15:8]; // [RL24]
              n.acc_low  = mv[7:0];  // [RL24]
            end
            OFS_PAGE:    n.page_base         = mv[7:0];
            OFS_INDEX1:  n.index_first       = mv[15:0];
            OFS_INDEX2:  n.index_second      = mv[15:0];
            OFS_PROG_SP: n.program_stack_ptr = mv[15:0];
            OFS_HW_SP: begin
              n.hardware_stack_ptr = mv[15:0];
              n.nmi_armed          = 1'b1; // [RL18]
            end
            OFS_PC:      n.program_counter = mv[15:0];
            OFS_FLAGS:   n.flags_register  = mv[7:0];
            OFS_OPERAND: n.operand         = mv[15:0];
            OFS_COMMAND: begin
              n.command     = mv[15:0];
              n.cmd_pending = 1'b1;
            end
            default: ;
          endcase
          n.bresp   = rd[32] && s.aw_addr != OFS_EFF_ADDR && s.aw_addr != OFS_STATUS ? RESP_OKAY : RESP_DECERR;
          n.aw_held = 1'b0;
          n.w_held  = 1'b0;
          n.bvalid  = 1'b1;
          n.state   = BUS_WRITE;
        end
      end
      BUS_WRITE: begin
        if (s.bvalid && bready) begin
          n.bvalid = 1'b0;
          n.state  = BUS_IDLE;
        end
      end
      BUS_READ: begin
        if (s.rvalid && rready) begin
          n.rvalid = 1'b0;
          n.state  = BUS_IDLE;
        end
      end
      default: n.state = BUS_IDLE;
    endcase
    // ----------------------------------------
    // Command execution
    // ----------------------------------------
    if (s.cmd_pending) begin
      n.cmd_pending = 1'b0;
      case (op)
        OP_ADD: begin
          a8 = alu8(n.acc_high, s.operand[7:0], 1'b0);
          flag8 = 1'b1;
          store = 1'b1;
        end
        OP_ADC: begin
          a8 = alu8(n.acc_high, s.operand[7:0], n.flags_register[FLAG_C]);
          flag8 = 1'b1;
          store = 1'b1;
        end
        OP_SUB, OP_CMP: begin
          a8 = alu8(n.acc_high, ~s.operand[7:0], 1'b1);
          flag8  = 1'b1;
          is_sub = 1'b1;
          store  = (op == OP_SUB);
        end
        OP_SBC: begin
          a8 = alu8(n.acc_high, ~s.operand[7:0], ~n.flags_register[FLAG_C]);
          flag8  = 1'b1;
          is_sub = 1'b1;
          store  = 1'b1;
        end
        OP_NEG: begin
          a8 = alu8(8'h00, ~n.acc_high, 1'b1);
          flag8  = 1'b1;
          is_sub = 1'b1;
          store  = 1'b1;
        end
        OP_ADD16, OP_SUB16: begin
          is_sub = (op == OP_SUB16);
          a16 = alu16({n.acc_high, n.acc_low}, is_sub ? ~s.operand : s.operand, is_sub); // [RL1]
          {n.acc_high, n.acc_low} = a16[15:0];
          n.flags_register[FLAG_N] = a16[15];           // [RL15]
          n.flags_register[FLAG_Z] = (a16[15:0] == 16'h0000); // [RL14]
          n.flags_register[FLAG_V] = a16[17];           // [RL13]
          n.flags_register[FLAG_C] = a16[16] ^ is_sub;  // [RL11] [RL12]
        end
        OP_MUL: begin
          prod = {8'h00, n.acc_high} * {8'h00, n.acc_low}; // [RL20]
          {n.acc_high, n.acc_low} = prod;
          n.flags_register[FLAG_Z] = (prod == 16'h0000); // [RL14]
        end
        OP_DIRECT: n.eff_addr = {n.page_base, s.operand[7:0]}; // [RL2]
        OP_PCREL:  n.eff_addr = n.program_counter + s.operand;  // [RL10]
        OP_INDEX: begin
          base = ptr_get(n, s.command[CMD_SEL_LSB +: 2]); // [RL6]
          case (s.command[CMD_OFS_LSB +: 2])
            OFS_CONST: ofs = s.operand;
            OFS_ACC:   ofs = {{8{n.acc_high[7]}}, n.acc_high};
            OFS_PAIR:  ofs = {n.acc_high, n.acc_low};
            default:   ofs = 16'h0000;
          endcase
          case (s.command[CMD_AUTO_LSB +: 2])
            AUTO_INC1, AUTO_INC2: begin
              n.eff_addr = base;
              base = base + ((s.command[CMD_AUTO_LSB +: 2] == AUTO_INC2) ? 16'h0002 : 16'h0001); // [RL5]
            end
            AUTO_DEC1: begin
              base = base - 16'h0001; // [RL5]
              n.eff_addr = base;
            end
            default: n.eff_addr = base + ofs; // [RL4]
          endcase
          case (s.command[CMD_SEL_LSB +: 2])
            2'h0:    n.index_first        = base;
            2'h1:    n.index_second       = base;
            2'h2:    n.program_stack_ptr  = base;
            default: n.hardware_stack_ptr = base;
          endcase
        end
        OP_PUSH, OP_PULL: begin
          cnt = stack_bytes(s.operand[7:0]); // [RL9]
          if (s.command[CMD_STK_BIT]) begin
            n.program_stack_ptr = (op == OP_PUSH) ? n.program_stack_ptr - {12'h000, cnt}
                                                  : n.program_stack_ptr + {12'h000, cnt}; // [RL7] [RL8]
          end else begin
            n.hardware_stack_ptr = (op == OP_PUSH) ? n.hardware_stack_ptr - {12'h000, cnt}
                                                   : n.hardware_stack_ptr + {12'h000, cnt}; // [RL7]
          end
        end
        OP_TRAP: begin
          case (s.command[CMD_OFS_LSB +: 2])
            2'h2:    n = enter(n, EV_SOFT2);
            2'h3:    n = enter(n, EV_SOFT3);
            default: n = enter(n, EV_SOFT1);
          endcase
        end
        OP_RETURN: begin
          // Operand carries the stacked flags; its entire bit sizes the pull
          cnt = stack_bytes(s.operand[FLAG_E] ? MASK_FULL : MASK_QUICK); // [RL23]
          n.hardware_stack_ptr = n.hardware_stack_ptr + {12'h000, cnt};
          n.flags_register     = s.operand[7:0];
        end
        default: ;
      endcase
      if (flag8) begin
        if (store) begin
          n.acc_high = a8[7:0];
        end
        n.flags_register[FLAG_N] = a8[7];              // [RL15]
        n.flags_register[FLAG_Z] = (a8[7:0] == 8'h00); // [RL14]
        n.flags_register[FLAG_V] = a8[9];              // [RL13]
        n.flags_register[FLAG_C] = a8[8] ^ is_sub;     // [RL11] [RL12]
        if (op == OP_ADD || op == OP_ADC) begin
          n.flags_register[FLAG_H] = a8[10];           // [RL21]
        end
      end
    end else if (!wrote) begin
      // ----------------------------------------
      // Interrupt entry, fixed priority
      // ----------------------------------------
      if (s.nmi_pend) begin
        n = enter(n, EV_NMI);
        n.nmi_pend = 1'b0;
      end else if (s.sync_quick[1] && !s.flags_register[FLAG_F]) begin
        n = enter(n, EV_QUICK); // [RL19] [RL22]
      end else if (s.sync_std[1] && !s.flags_register[FLAG_I]) begin
        n = enter(n, EV_STD); // [RL16]
      end
    end
    // Unarmed edges are dropped; a new edge wins over the clear
    if (s.nmi_armed && s.sync_nmi[1] && !s.sync_nmi[2]) begin
      n.nmi_pend = 1'b1; // [RL18]
    end
    n.awready = (n.state == BUS_IDLE) && !n.aw_held;
    n.wready  = (n.state == BUS_IDLE) && !n.w_held;
    n.arready = (n.state == BUS_IDLE) && !(n.aw_held && n.w_held);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.flags_register <= FLAGS_RESET; // [RL17] [RL22]
      s.page_base      <= 8'h00;       // [RL3]
    end else begin
      s <= n;
    end
  end
  assign awready      = s.awready;
  assign wready       = s.wready;
  assign arready      = s.arready;
  assign bvalid       = s.bvalid;
  assign bresp        = s.bresp;
  assign rvalid       = s.rvalid;
  assign rresp        = s.rresp;
  assign rdata        = s.rdata;
  assign addr_out     = s.eff_addr;
  assign event_code   = s.event_code;
  assign event_strobe = s.event_strobe;
endmodule
`default_nettype wire

//--- test/regs_checker.sv
// Purpose: Port checks for the register file
// Assumes: Bound into every register file instance
// Notes:   NMI gate counts the stack write from its address phase
`timescale 1ns/1ps
`default_nettype none
module regs_checker
  import cpu_regs_pkg::*;
(
  input wire logic                 aclk, aresetn, awvalid, awready, wready, bvalid, // Clock, write side
  input wire logic                 bready, arvalid, arready, rvalid, rready,        // Handshakes
  input wire logic                 event_strobe,                                  // Entry pulse
  input wire logic [ADDR_BITS-1:0] awaddr, araddr,                                // Addresses
  input wire logic [31:0]          rdata,                                         // Read data
  input wire logic [1:0]           rresp,                                         // Read response
  input wire logic [2:0]           event_code                                     // Last entry
);
  logic sp_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) sp_seen <= 1'b0;
    else if (awvalid && awready && awaddr == OFS_HW_SP) sp_seen <= 1'b1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ready_up; $rose(aresetn) |=> awready && wready && arready; endproperty
  property p_busy; bvalid || rvalid |-> !awready && !wready && !arready; endproperty
  property p_b_done; bvalid && bready |=> !bvalid; endproperty
  property p_r_lat; arvalid && arready |=> rvalid; endproperty
  property p_r_done; rvalid && rready |=> !rvalid; endproperty
  property p_unmapped; arvalid && arready && araddr == 8'h3c |=> rresp == RESP_DECERR && rdata == '0; endproperty
  property p_ev_code; event_strobe |-> event_code inside {[EV_NMI:EV_SOFT3]}; endproperty
  property p_nmi_gate; event_strobe && event_code == EV_NMI |-> sp_seen; endproperty
  a_ready_up: assert property (p_ready_up) else $error("readies late");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_b_done: assert property (p_b_done) else $error("bvalid stuck");
  a_r_lat: assert property (p_r_lat) else $error("read late");
  a_r_done: assert property (p_r_done) else $error("rvalid stuck");
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
  a_ev_code: assert property (p_ev_code) else $error("bad event code");
  a_nmi_gate: assert property (p_nmi_gate) else $error("early nmi");
  c_nmi: cover property (event_strobe && event_code == EV_NMI);
  c_write: cover property (bvalid && bready);
  c_decerr: cover property (rvalid && rready && rresp == RESP_DECERR);
endmodule
bind cpu_register_file_and_flags regs_checker regs_checker_inst (.*);
`default_nettype wire

//--- test/cpu_register_file_and_flags_tb.sv
// Purpose: Bus-level tests of the register file
// Assumes: One access at a time; bready and rready stay high
// Notes:   Flags carry over from one arithmetic row to the next
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_and_flags_tb
  import cpu_regs_pkg::*;
;
  logic                 aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic                 arvalid = 1'b0, rready = 1'b1, nmi_n = 1'b1, quick_request_n = 1'b1;
  logic                 std_request_n = 1'b1, awready, wready, bvalid, arready, rvalid, event_strobe;
  logic [ADDR_BITS-1:0] awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0, rdata;
  logic [3:0]           wstrb = 4'hf;
  logic [1:0]           bresp, rresp, last_b;
  logic [15:0]          addr_out;
  logic [2:0]           event_code;
  int                   errors = 0, checks = 0;
  // A, operand, opcode, result, flags
  logic [39:0]          tv [7] = '{40'h7f_0100_807a, 40'h80_8000_0057, 40'h00_0102_ff59,
                                   40'h05_0504_0554, 40'h01_0005_ff59, 40'h10_0503_0a50, 40'h08_0801_1070};
  always #50 aclk = ~aclk;
  cpu_register_file_and_flags cpu_register_file_and_flags_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_b = bresp;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk({30'h0, rresp}, {30'h0, (a > OFS_STATUS) ? RESP_DECERR : RESP_OKAY});
    chk(rdata, {16'h0000, e});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(OFS_PAGE, 16'h0000);
    rd(OFS_FLAGS, 16'h0050);
    std_request_n   <= 1'b0;
    quick_request_n <= 1'b0;
    nmi_n           <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({29'h0, event_code}, {29'h0, EV_NONE});
    std_request_n   <= 1'b1;
    quick_request_n <= 1'b1;
    nmi_n           <= 1'b1;
    wr(OFS_PAIRED, 16'h1234);
    rd(OFS_ACC_HIGH, 16'h0012);
    rd(OFS_ACC_LOW, 16'h0034);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_ACC_HIGH, {8'h00, tv[i][39:32]});
      wr(OFS_OPERAND, {8'h00, tv[i][31:24]});
      wr(OFS_COMMAND, {8'h00, tv[i][23:16]});
      rd(OFS_ACC_HIGH, {8'h00, tv[i][15:8]});
      rd(OFS_FLAGS, {8'h00, tv[i][7:0]});
    end
    wr(OFS_PAIRED, 16'hffff);
    wr(OFS_COMMAND, 16'h0008);
    rd(OFS_PAIRED, 16'hfe01);
    wr(OFS_PAGE, 16'h00ab);
    wr(OFS_OPERAND, 16'h0034);
    wr(OFS_COMMAND, 16'h0009);
    rd(OFS_EFF_ADDR, 16'hab34);
    chk({16'h0000, addr_out}, 32'h0000_ab34);
    wr(OFS_INDEX2, 16'h1000);
    wr(OFS_COMMAND, 16'h081a);
    rd(OFS_EFF_ADDR, 16'h1000);
    rd(OFS_INDEX2, 16'h1002);
    wr(OFS_OPERAND, 16'h00ff);
    wr(OFS_COMMAND, 16'h004b);
    rd(OFS_PROG_SP, 16'hfff4);
    wr(OFS_PC, 16'h0100);
    wr(OFS_COMMAND, 16'h000f);
    rd(OFS_EFF_ADDR, 16'h01ff);
    wr(OFS_EFF_ADDR, 16'hffff);
    chk({30'h0, last_b}, {30'h0, RESP_DECERR});
    rd(8'h3c, 16'h0000);
    wr(OFS_HW_SP, 16'h0100);
    wr(OFS_FLAGS, 16'h0000);
    wr(OFS_COMMAND, 16'h020d);
    rd(OFS_FLAGS, 16'h0080);
    rd(OFS_HW_SP, 16'h00f4);
    chk({29'h0, event_code}, {29'h0, EV_SOFT2});
    wr(OFS_COMMAND, 16'h010d);
    rd(OFS_FLAGS, 16'h00d0);
    rd(OFS_HW_SP, 16'h00e8);
    nmi_n <= 1'b0;
    do @(posedge aclk);
    while (!event_strobe);
    chk({29'h0, event_code}, {29'h0, EV_NMI});
    nmi_n <= 1'b1;
    rd(OFS_HW_SP, 16'h00dc);
    wr(OFS_FLAGS, 16'h0000);
    quick_request_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({29'h0, event_code}, {29'h0, EV_QUICK});
    quick_request_n <= 1'b1;
    rd(OFS_HW_SP, 16'h00d9);
    final_report;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    errors++;
    final_report;
  end
endmodule
`default_nettype wire
